// [design/sacs_pkg.sv]
// Constants and types of the converter sequencer
//
// Contract
// - A control-byte write starts tracking the selected positive input at write end.
// - In external acquisition, the next write ends tracking and starts hold.
// - In internal acquisition, hold begins on the fourth falling clock edge.
// - Every conversion takes 13 conversion clock cycles in all modes.
// - A write during conversion abandons it and starts a new acquisition.
// - The acquisition bit picks acquisition-only or acquisition plus automatic conversion.
// - The sample is taken when track-and-hold switches from track to hold.
// - Single-ended mode routes channel to positive input, ground reference to negative.
// - Pseudo-differential mode routes both inputs from a channel pair.
// - Successive approximation yields a 12-bit result read as eight plus four bits.
// - Completion flag goes low at valid result, high on read or write.
// - Upper nibble select high reads four MSBs; low reads eight LSBs.
// - Data lines are not driven while chip select is high.
// - Control bit five selects acquisition: 0 internal, 1 external.
package sacs_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int INT_CLK_PERIOD_NS = 250;
  localparam int INT_CLK_DIV = INT_CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_CLK_DIV - 1);
  localparam int ACQ_EDGES = 4;
  localparam logic [2:0] ACQ_LAST = 3'(ACQ_EDGES - 1);
  localparam int RES_BITS = 12;
  localparam int CONV_CYCLES = 13;
  localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);
  localparam logic [3:0] RES_BITS_C = 4'(RES_BITS);
  localparam logic [RES_BITS-1:0] TRIAL_MSB = 12'h800;
  // ---------------------------------------------------------------
  // Control byte fields
  // ---------------------------------------------------------------
  localparam int CB_PD_LO = 6;
  localparam int CB_ACQ = 5;
  localparam int CB_PAIR = 4;
  localparam int CB_POL = 3;
  localparam int CB_CH_HI = 2;
  localparam int CB_CH_LO = 0;
  localparam logic [1:0] PD_INT_CLK = 2'h2;
  localparam logic [1:0] PD_EXT_CLK = 2'h3;
  localparam logic [7:0] CFG_RST = 8'hD0;
  localparam int LOW_W = 8;
  localparam int NIB_W = 4;
  // ---------------------------------------------------------------
  // Input synchroniser layout
  // ---------------------------------------------------------------
  localparam int SY_CS = 0;
  localparam int SY_WR = 1;
  localparam int SY_RD = 2;
  localparam int SY_HB = 3;
  localparam int SY_CLK = 4;
  localparam int SY_CMP = 5;
  localparam int SY_DAT = 6;
  localparam int SYNC_W = 14;
  localparam logic [SYNC_W-1:0] SYNC_RST = 14'h3FFF;
  typedef enum logic [1:0] {
    SACS_IDLE = 2'h0,
    SACS_TRACK = 2'h1,
    SACS_CONV = 2'h3
  } sacs_state_t;
endpackage

// [design/sacs_sar_if.sv]
// Link between the sequencer and its approximation engine
`timescale 1ns/1ps
`default_nettype none
interface sacs_sar_if;
  import sacs_pkg::*;
  logic start;
  logic abort;
  logic tick;
  logic cmp_keep;
  logic done;
  logic [RES_BITS-1:0] trial;
  logic [RES_BITS-1:0] result;
  modport ctrl(output start, output abort, output tick, output cmp_keep,
               input done, input trial, input result);
  modport engine(input start, input abort, input tick, input cmp_keep,
                 output done, output trial, output result);
endinterface
`default_nettype wire

// [design/sacs_sar_engine.sv]
// Successive approximation engine, one step per conversion clock
`timescale 1ns/1ps
`default_nettype none
module sacs_sar_engine
  import sacs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  sacs_sar_if.engine sar
);
  logic busy;
  logic next_busy;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [RES_BITS-1:0] trial;
  logic [RES_BITS-1:0] next_trial;
  logic [RES_BITS-1:0] result;
  logic [RES_BITS-1:0] next_result;
  logic done;
  logic next_done;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] idx;
    idx = RES_BITS_C - cnt;
    next_busy = busy;
    next_cnt = cnt;
    next_trial = trial;
    next_result = result;
    next_done = 1'b0;
    if (sar.abort || sar.start) begin
      next_busy = sar.start;
      next_cnt = '0;
      next_trial = '0;
    end else if (busy && sar.tick) begin
      // First cycle moves the held charge; then one bit per cycle
      if (cnt == '0) begin
        next_trial = TRIAL_MSB;
      end else begin
        next_trial[idx] = sar.cmp_keep;
        if (idx != '0) begin
          next_trial[idx - 4'h1] = 1'b1;
        end
      end
      if (cnt == CONV_LAST) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_result = next_trial;
        next_cnt = '0;
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      cnt <= '0;
      trial <= '0;
      result <= '0;
      done <= 1'b0;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      trial <= next_trial;
      result <= next_result;
      done <= next_done;
    end
  end

  assign sar.trial = trial;
  assign sar.result = result;
  assign sar.done = done;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  conv_length_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done |-> $past(cnt) == CONV_LAST && $past(busy) && $past(sar.tick))
    else $error("conversion ended after the wrong number of cycles");
  result_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !done |-> $stable(result))
    else $error("result changed without a completed conversion");
endmodule
`default_nettype wire

// [design/sacs_top.sv]
// Conversion sequencer with byte-wide host port
`timescale 1ns/1ps
`default_nettype none
module sacs_top
  import sacs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic upper_nibble_select,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic done_n,
  input wire logic conv_clk,
  input wire logic cmp_keep_pin,
  output logic [RES_BITS-1:0] dac_trial,
  output logic track_hold,
  output logic [2:0] pos_sel,
  output logic [2:0] neg_sel,
  output logic neg_to_ground_ref,
  output logic polarity_bit,
  output logic [1:0] power_clock_select_bits,
  output logic internal_clock_mode
);
  sacs_sar_if sar();

  sacs_sar_engine u_engine (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sar(sar.engine)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] prev;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      prev <= SYNC_RST;
    end else begin
      sync1 <= {data_in, cmp_keep_pin, conv_clk, upper_nibble_select,
                rd_n, wr_n, cs_n};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  logic cs_n_s;
  logic [7:0] byte_s;
  logic write_evt;
  logic read_evt;
  logic ext_fall;
  assign cs_n_s = sync2[SY_CS];
  assign byte_s = sync2[SY_DAT +: 8];
  // Write taken at strobe rise while select was low
  assign write_evt = !prev[SY_WR] && sync2[SY_WR] && !prev[SY_CS];
  assign read_evt = prev[SY_RD] && !sync2[SY_RD] && !cs_n_s;
  assign ext_fall = prev[SY_CLK] && !sync2[SY_CLK];

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  sacs_state_t state;
  sacs_state_t next_state;
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic [2:0] acq_cnt;
  logic [2:0] next_acq_cnt;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic int_mode;
  logic next_int_mode;
  logic done_flag;
  logic next_done_flag;
  logic next_done_n;
  logic track;
  logic next_track;
  logic [7:0] next_data_out;
  logic next_data_oe;
  logic [2:0] next_pos_sel;
  logic [2:0] next_neg_sel;
  logic next_neg_gnd;
  logic tick;
  logic start;
  logic abort;
  logic acq_ext;

  assign acq_ext = cfg[CB_ACQ];

  always_comb begin
    logic [2:0] ch;
    ch = cfg[CB_CH_HI:CB_CH_LO];
    next_state = state;
    next_cfg = cfg;
    next_acq_cnt = acq_cnt;
    next_int_mode = int_mode;
    next_track = track;
    start = 1'b0;
    abort = 1'b0;
    // Internal oscillator: one falling edge per divider wrap
    next_div_cnt = (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
    tick = int_mode ? (div_cnt == DIV_LAST) : ext_fall;
    if (write_evt) begin
      next_cfg = byte_s;
      if (byte_s[CB_PD_LO +: 2] == PD_INT_CLK) begin
        next_int_mode = 1'b1;
      end else if (byte_s[CB_PD_LO +: 2] == PD_EXT_CLK) begin
        next_int_mode = 1'b0;
      end
      if (state == SACS_TRACK && acq_ext) begin
        // Second write closes the acquisition window
        next_state = SACS_CONV;
        next_track = 1'b0;
        start = 1'b1;
      end else begin
        abort = (state == SACS_CONV);
        next_state = SACS_TRACK;
        next_track = 1'b1;
        next_acq_cnt = '0;
      end
    end else begin
      unique case (state)
        SACS_IDLE: begin
        end
        SACS_TRACK: begin
          // Only internal acquisition converts on its own
          if (!acq_ext && tick) begin
            if (acq_cnt == ACQ_LAST) begin
              next_state = SACS_CONV;
              next_track = 1'b0;
              start = 1'b1;
            end else begin
              next_acq_cnt = acq_cnt + 3'h1;
            end
          end
        end
        SACS_CONV: begin
          if (sar.done) begin
            next_state = SACS_IDLE;
          end
        end
        default: begin
          next_state = SACS_IDLE;
          next_track = 1'b0;
        end
      endcase
    end
    // Completion wins over a clearing read or write
    if (sar.done) begin
      next_done_flag = 1'b1;
    end else if (read_evt || write_evt) begin
      next_done_flag = 1'b0;
    end else begin
      next_done_flag = done_flag;
    end
    next_done_n = !next_done_flag;
    // Input routing from channel address and pairing
    ch = next_cfg[CB_CH_HI:CB_CH_LO];
    if (next_cfg[CB_PAIR]) begin
      next_pos_sel = ch;
      next_neg_sel = ch;
      next_neg_gnd = 1'b1;
    end else begin
      next_pos_sel = ch;
      next_neg_sel = {ch[2:1], ~ch[0]};
      next_neg_gnd = 1'b0;
    end
    // Read mux and bus drive
    if (sync2[SY_HB]) begin
      next_data_out = {{(LOW_W-NIB_W){1'b0}},
                       sar.result[RES_BITS-1 -: NIB_W]};
    end else begin
      next_data_out = sar.result[LOW_W-1:0];
    end
    next_data_oe = !cs_n_s && !sync2[SY_RD];
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SACS_IDLE;
      cfg <= CFG_RST;
      acq_cnt <= '0;
      div_cnt <= '0;
      int_mode <= 1'b0;
      done_flag <= 1'b0;
      done_n <= 1'b1;
      track <= 1'b0;
      data_out <= '0;
      data_oe <= 1'b0;
      pos_sel <= '0;
      neg_sel <= '0;
      neg_to_ground_ref <= 1'b1;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      acq_cnt <= next_acq_cnt;
      div_cnt <= next_div_cnt;
      int_mode <= next_int_mode;
      done_flag <= next_done_flag;
      done_n <= next_done_n;
      track <= next_track;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      pos_sel <= next_pos_sel;
      neg_sel <= next_neg_sel;
      neg_to_ground_ref <= next_neg_gnd;
    end
  end

  assign sar.start = start;
  assign sar.abort = abort;
  assign sar.tick = tick;
  assign sar.cmp_keep = sync2[SY_CMP];
  assign track_hold = track;
  assign dac_trial = sar.trial;
  assign polarity_bit = cfg[CB_POL];
  assign power_clock_select_bits = cfg[CB_PD_LO +: 2];
  assign internal_clock_mode = int_mode;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence write_in_ext_track;
    write_evt && state == SACS_TRACK && acq_ext;
  endsequence
  sequence fourth_edge;
    !write_evt && state == SACS_TRACK && !acq_ext && tick &&
      acq_cnt == ACQ_LAST;
  endsequence
  sequence fresh_write;
    write_evt && !(state == SACS_TRACK && acq_ext);
  endsequence

  track_start_a: assert property (fresh_write |=> track_hold &&
    state == SACS_TRACK && acq_cnt == '0)
    else $error("write did not start tracking");
  ext_hold_a: assert property (write_in_ext_track |=> !track_hold
    && state == SACS_CONV)
    else $error("second write did not enter hold");
  int_hold_a: assert property (fourth_edge |=> !track_hold &&
    state == SACS_CONV)
    else $error("hold not entered on fourth falling edge");
  early_hold_a: assert property (state == SACS_TRACK &&
    !$past(write_evt) && $past(state) == SACS_TRACK && acq_ext |->
    track_hold)
    else $error("external acquisition ended without a write");
  abort_conv_a: assert property (write_evt && state == SACS_CONV
    |-> abort ##1 state == SACS_TRACK)
    else $error("write during conversion did not restart acquisition");
  route_single_a: assert property (cfg[CB_PAIR] |=>
    neg_to_ground_ref || $past(write_evt))
    else $error("single-ended negative input not on ground reference");
  flag_set_a: assert property (sar.done |=> !done_n)
    else $error("completion flag not set at end of conversion");
  flag_clear_a: assert property (read_evt && !sar.done |=> done_n)
    else $error("completion flag not released by a read");
  bus_idle_a: assert property (cs_n_s |=> !data_oe)
    else $error("data lines driven while deselected");
  nibble_read_a: assert property (sync2[SY_HB] |=>
    data_out[LOW_W-1:NIB_W] == '0)
    else $error("upper nibble read shows stray bits");

  // Read path follows the synced pins one cycle later
  sequence bus_read;
    !cs_n_s && !sync2[SY_RD];
  endsequence
  sequence low_read;
    !sync2[SY_HB];
  endsequence

  bus_drive_a: assert property (bus_read |=> data_oe)
    else $error("data lines not driven during a read");
  low_byte_a: assert property (low_read |=>
    data_out == $past(sar.result[LOW_W-1:0]))
    else $error("low byte read shows wrong bits");
  upper_nibble_a: assert property (sync2[SY_HB] |=>
    data_out[NIB_W-1:0] == $past(sar.result[RES_BITS-1 -: NIB_W]))
    else $error("upper nibble read shows wrong bits");
  track_level_a: assert property (track_hold ==
    (state == SACS_TRACK))
    else $error("track switch out of step with sequencer");
  hold_sample_a: assert property ($fell(track_hold) |->
    state == SACS_CONV && $past(state) == SACS_TRACK)
    else $error("hold entered without starting a conversion");
  write_capture_a: assert property (write_evt |=>
    cfg == $past(byte_s))
    else $error("control byte not captured at strobe rise");
  flag_write_a: assert property (write_evt && !sar.done |=> done_n)
    else $error("completion flag not released by a write");
  route_pair_a: assert property (!next_cfg[CB_PAIR] |=>
    !neg_to_ground_ref && neg_sel == {pos_sel[2:1], ~pos_sel[0]})
    else $error("pseudo-differential pair not routed");
endmodule
`default_nettype wire

// [verification/sacs_host_model.sv]
// Host processor model driving the byte-wide port
`timescale 1ns/1ps
`default_nettype none
module sacs_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic upper_nibble_select,
  output logic [7:0] data_in
);
  initial begin
    cs_n = 1'h1;
    wr_n = 1'h1;
    rd_n = 1'h1;
    upper_nibble_select = 1'h0;
    data_in = 8'h00;
  end
  // Write cycle; sel_n high makes a deselected strobe
  task automatic wr(input logic [7:0] b, input logic sel_n);
    @(posedge clk_sys);
    cs_n <= sel_n;
    wr_n <= 1'h0;
    data_in <= b;
    repeat (4) @(posedge clk_sys);
    wr_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'h1;
    data_in <= ~b;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic rd(input logic hi, input logic sel_n, output logic [7:0] d,
                    output logic oe);
    @(posedge clk_sys);
    cs_n <= sel_n;
    upper_nibble_select <= hi;
    rd_n <= 1'h0;
    repeat (6) @(posedge clk_sys);
    d = data_out;
    oe = data_oe;
    rd_n <= 1'h1;
    cs_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [verification/tb_sar_adc_conversion_sequencer.sv]
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_conversion_sequencer;
  import sacs_pkg::*;
  logic clk_sys, sys_rst, cs_n, wr_n, rd_n, upper_nibble_select, data_oe;
  logic done_n, conv_clk, cmp_keep_pin, track_hold, neg_to_ground_ref;
  logic polarity_bit, internal_clock_mode, pair, pol;
  logic [7:0] data_in, data_out, cfg;
  logic [RES_BITS-1:0] dac_trial, target;
  logic [2:0] pos_sel, neg_sel;
  logic [1:0] power_clock_select_bits;
  int mismatches, n_checks, cycles, k;

  sacs_top sacs_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .upper_nibble_select(upper_nibble_select),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .done_n(done_n), .conv_clk(conv_clk), .cmp_keep_pin(cmp_keep_pin),
    .dac_trial(dac_trial), .track_hold(track_hold), .pos_sel(pos_sel),
    .neg_sel(neg_sel), .neg_to_ground_ref(neg_to_ground_ref),
    .polarity_bit(polarity_bit),
    .power_clock_select_bits(power_clock_select_bits),
    .internal_clock_mode(internal_clock_mode));
  sacs_host_model sacs_host_model_i (.clk_sys(clk_sys), .data_out(data_out),
    .data_oe(data_oe), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .upper_nibble_select(upper_nibble_select), .data_in(data_in));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Comparator: keep the trial bit while the input is not below it
  always @(posedge clk_sys) cmp_keep_pin <= (target >= dac_trial);
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("ERROR %0t timeout", $time);
      wrap_up();
    end
  end

  function automatic logic [7:0] exp_half(input logic [11:0] v,
                                          input logic hi);
    return hi ? {4'h0, v[11:8]} : v[7:0];
  endfunction
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'h1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // Falling edges on the external conversion clock, 8 cycles each
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys) conv_clk <= 1'h0;
      repeat (4) @(posedge clk_sys);
      conv_clk <= 1'h1;
      repeat (3) @(posedge clk_sys);
    end
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic read_result(input logic [11:0] v);
    logic [7:0] d;
    logic oe;
    sacs_host_model_i.rd(1'h1, 1'h0, d, oe);
    chk(d === exp_half(v, 1'h1) && oe === 1'h1, "upper nibble");
    chk(done_n === 1'h1, "flag kept after read");
    sacs_host_model_i.rd(1'h0, 1'h0, d, oe);
    chk(d === exp_half(v, 1'h0), "low byte");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    sys_rst = 1'h1;
    conv_clk = 1'h1;
    target = 12'h000;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'h0;
    void'($urandom(79));
    @(posedge clk_sys);
    chk(done_n === 1'h1 && data_oe === 1'h0 && track_hold === 1'h0 &&
        neg_to_ground_ref === 1'h1 && internal_clock_mode === 1'h0 &&
        power_clock_select_bits === 2'h3, "reset values");
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      pair = (i < 2) ? 1'(i) : 1'($urandom);
      pol = 1'($urandom);
      cfg = {2'h3, 1'h0, pair, pol, 3'(i)};
      target <= (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($urandom);
      sacs_host_model_i.wr(cfg, 1'h0);
      chk(track_hold === 1'h1, "not tracking");
      chk(pos_sel === 3'(i) && polarity_bit === pol, "channel");
      chk(neg_to_ground_ref === pair, "pairing");
      if (!pair) chk(neg_sel === (3'(i) ^ 3'h1), "pair partner");
      pulses(3);
      chk(track_hold === 1'h1, "hold too early");
      pulses(1);
      chk(track_hold === 1'h0, "no hold");
      pulses(12);
      chk(done_n === 1'h1, "done too early");
      pulses(1);
      chk(done_n === 1'h0, "no done");
      read_result(target);
    end
    $display("internal acquisition test done");
    cfg = 8'hFD;
    target <= 12'($urandom);
    sacs_host_model_i.wr(cfg, 1'h0);
    pulses(6);
    chk(track_hold === 1'h1, "external track ended");
    sacs_host_model_i.wr(cfg & 8'hDF, 1'h0);
    chk(track_hold === 1'h0, "second write no hold");
    pulses(13);
    chk(done_n === 1'h0, "external no done");
    sacs_host_model_i.wr(8'hDA, 1'h0);
    chk(done_n === 1'h1, "flag kept after write");
    pulses(4);
    pulses(5);
    target <= 12'($urandom);
    sacs_host_model_i.wr(8'hDA, 1'h0);
    chk(track_hold === 1'h1 && done_n === 1'h1, "no abort");
    pulses(17);
    chk(done_n === 1'h0, "restart no done");
    sacs_host_model_i.wr(8'h00, 1'h1);
    chk(track_hold === 1'h0 && done_n === 1'h0, "deselected write");
    sacs_host_model_i.rd(1'h0, 1'h1, cfg, pair);
    chk(pair === 1'h0 && done_n === 1'h0, "deselected read");
    read_result(target);
    $display("external and abort test done");
    target <= 12'($urandom);
    sacs_host_model_i.wr(8'h9A, 1'h0);
    chk(internal_clock_mode === 1'h1, "no internal clock");
    sacs_host_model_i.wr(8'h1A, 1'h0);
    chk(internal_clock_mode === 1'h1 && power_clock_select_bits === 2'h0,
        "clock mode lost");
    k = 0;
    while (done_n !== 1'h0 && k < 20 * INT_CLK_DIV) begin
      @(posedge clk_sys);
      k++;
    end
    chk(k >= 15 * INT_CLK_DIV && k <= 18 * INT_CLK_DIV, "osc timing");
    read_result(target);
    $display("internal clock test done");
    wrap_up();
  end
endmodule
`default_nettype wire
